// *** rtl/lgp_pkg.sv ***
package lgp_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS     = 5;
  localparam int INT_CLK_PERIOD_NS = 100;
  localparam int INT_HALF_CYC      = INT_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int LATCH_DELAY_NS    = 1000;
  localparam int LATCH_DELAY_CYC   = (LATCH_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sizes
  localparam int SHIFT_W  = 224;
  localparam int NUM_CH   = 12;
  localparam int GS_W     = 16;
  localparam int BC_W     = 7;
  localparam int SEG_W    = 7;
  localparam int POS_W    = 9;
  localparam int TIMER_W  = 8;
  localparam int INT_DIV_W = 4;

  // Latch field positions
  localparam int EDGE_SEL_BIT = 217;
  localparam int CLK_SRC_BIT  = 216;
  localparam int BLANK_BIT    = 213;
  localparam int BC_BLUE_LSB  = 206;
  localparam int BC_GREEN_LSB = 199;
  localparam int BC_RED_LSB   = 192;
  localparam int GS_LSB       = 0;

  // Values after reset
  localparam logic                 BLANK_RST = 1'b1;
  localparam logic [GS_W-1:0]      GS_RST    = 16'h0000;
  localparam logic [BC_W-1:0]      BC_RST    = 7'h00;
  localparam logic [SHIFT_W-1:0]   SHIFT_RST = '0;

  // Cycle counts at register width
  localparam logic [TIMER_W-1:0]   LATCH_DELAY_LD = TIMER_W'(LATCH_DELAY_CYC);
  localparam logic [INT_DIV_W-1:0] INT_DIV_END    = INT_DIV_W'(INT_HALF_CYC - 1);

  typedef logic [GS_W-1:0] lgp_gs_t;
  typedef logic [BC_W-1:0] lgp_bc_t;

  typedef enum logic [1:0] {
    LGP_IDLE  = 2'b01,
    LGP_ARMED = 2'b10
  } lgp_latch_state_t;

  function automatic logic [SEG_W-1:0] lgp_bitrev(input logic [SEG_W-1:0] v);
    logic [SEG_W-1:0] r;
    r = '0;
    for (int i = 0; i < SEG_W; i++)
    begin
      r[i] = v[SEG_W-1-i];
    end
    return r;
  endfunction

  // Segment rank is the bit-reversed segment index, so the remainder clocks
  // land spread over the whole cycle instead of bunched at its start.
  function automatic logic lgp_es_on(input lgp_gs_t gs, input lgp_gs_t cnt);
    logic [SEG_W-1:0] rank;
    logic [POS_W:0]   limit;
    rank  = lgp_bitrev(cnt[GS_W-1:POS_W]);
    limit = {1'b0, gs[GS_W-1:SEG_W]} + {{POS_W{1'b0}}, (rank < gs[SEG_W-1:0])};
    return {1'b0, cnt[POS_W-1:0]} < limit;
  endfunction

endpackage

// *** rtl/lgp_gs_if.sv ***
`timescale 1ns/10ps
interface lgp_gs_if;
  logic                                       load;
  logic [lgp_pkg::GS_W*lgp_pkg::NUM_CH-1:0]   load_gs;
  logic                                       blank;
  lgp_pkg::lgp_gs_t                           count;
  logic [lgp_pkg::NUM_CH-1:0]                 on;

  modport ctrl (output load, output load_gs, output blank, output count, input on);
  modport bank (input load, input load_gs, input blank, input count, output on);
endinterface

// *** rtl/lgp_gs_bank.sv ***
`timescale 1ns/10ps
module lgp_gs_bank (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  lgp_gs_if.bank    gs_if
);
  import lgp_pkg::*;

  lgp_gs_t             mem_r [NUM_CH];
  logic [NUM_CH-1:0]   on_r;
  wire  [NUM_CH-1:0]   on_nxt;

  genvar n;
  generate
    for (n = 0; n < NUM_CH; n++)
    begin : g_ch
      assign on_nxt[n] = ~gs_if.blank & lgp_es_on(mem_r[n], gs_if.count);
    end
  endgenerate

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        mem_r[i] <= GS_RST;
      end
      on_r <= '0;
    end
    else if (ce_i)
    begin
      if (gs_if.load)
      begin
        for (int i = 0; i < NUM_CH; i++)
        begin
          mem_r[i] <= gs_if.load_gs[GS_LSB + i*GS_W +: GS_W];
        end
      end
      on_r <= on_nxt;
    end
  end

  assign gs_if.on = on_r;

  AST_GS_ZERO_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && mem_r[0] == GS_RST) |=> !on_r[0])
    else $error("zero grayscale channel turned on");

  AST_BLANK_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && gs_if.blank) |=> (on_r == '0))
    else $error("output on while disabled");

  AST_GS_FULL_ON: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !gs_if.blank && mem_r[1] == 16'hffff && gs_if.count != 16'hffff) |=> on_r[1])
    else $error("full grayscale channel not on");

  AST_SEG_POS_LAST: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && gs_if.count[POS_W-1:0] == 9'h1ff && mem_r[2][GS_W-1:SEG_W] != 9'h1ff
     && mem_r[2][SEG_W-1:0] == 7'h00) |=> !on_r[2])
    else $error("segment overran its share");

endmodule

// *** rtl/lgp_top.sv ***
`timescale 1ns/10ps
// Behaviour
// - Seven-bit brightness held per colour group
// - New brightness applies at once
// - Current equals full scale times value over 127
// - Group value applies to all four outputs
// - Output disable set at power-up
// - Shift register and latch otherwise undefined
// - Sixteen-bit grayscale value per output
// - One shared sixteen-bit grayscale counter
// - Counter steps on selected reference edge
// - External source uses shift clock input
// - Disable clears, holds counter, forces outputs off
// - On-time is value times clock period
// - Zero stays off, maximum stays on for all but one count of the 65536-count cycle
// - Latch strobe follows last shift edge
// - Data enters shift register at bottom
// - On-time spread over 128 segments
module lgp_top #(
  parameter logic RISE_ON_SEL1 = 1'b1
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  input  wire logic                       shift_clock_in_i,
  input  wire logic                       serial_data_in_i,
  output logic                            serial_data_out_o,
  output logic [lgp_pkg::NUM_CH-1:0]      sink_output_o,
  output lgp_pkg::lgp_bc_t                group_brightness_value_red_o,
  output lgp_pkg::lgp_bc_t                group_brightness_value_green_o,
  output lgp_pkg::lgp_bc_t                group_brightness_value_blue_o
);
  import lgp_pkg::*;

  // Pin synchronisers
  logic                 sck_meta_r;
  logic                 sck_sync_r;
  logic                 sck_prev_r;
  logic                 sdi_meta_r;
  logic                 sdi_sync_r;

  // Shift register and latch sequencer
  logic [SHIFT_W-1:0]   shift_r;
  lgp_latch_state_t     state_r;
  lgp_latch_state_t     state_nxt;
  logic [TIMER_W-1:0]   timer_r;
  logic [TIMER_W-1:0]   timer_nxt;

  // Latched control fields
  logic                 edge_sel_r;
  logic                 clk_src_r;
  logic                 blank_r;
  lgp_bc_t              bc_red_r;
  lgp_bc_t              bc_green_r;
  lgp_bc_t              bc_blue_r;

  // Internal oscillator and counter
  logic [INT_DIV_W-1:0] int_div_r;
  logic                 int_clk_r;
  lgp_gs_t              gs_count_r;
  lgp_gs_t              gs_count_nxt;

  wire sck_rise = sck_sync_r & ~sck_prev_r;
  wire sck_fall = ~sck_sync_r & sck_prev_r;
  wire int_wrap = (int_div_r == INT_DIV_END);
  wire int_rise = int_wrap & ~int_clk_r;
  wire int_fall = int_wrap & int_clk_r;

  wire ref_rise = clk_src_r ? sck_rise : int_rise;
  wire ref_fall = clk_src_r ? sck_fall : int_fall;
  wire use_rise = edge_sel_r ? RISE_ON_SEL1 : ~RISE_ON_SEL1;
  wire gs_tick  = use_rise ? ref_rise : ref_fall;

  wire [SHIFT_W-1:0] shift_nxt = sck_rise ? {shift_r[SHIFT_W-2:0], sdi_sync_r} : shift_r;

  // Quiet time after the final edge fires the strobe, whatever the bit count
  wire latch_strobe = (state_r == LGP_ARMED) & ~sck_rise & (timer_r == 8'h01);

  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    unique case (state_r)
      LGP_IDLE:
      begin
        if (sck_rise)
        begin
          state_nxt = LGP_ARMED;
          timer_nxt = LATCH_DELAY_LD;
        end
      end
      LGP_ARMED:
      begin
        if (sck_rise)
        begin
          timer_nxt = LATCH_DELAY_LD;
        end
        else if (latch_strobe)
        begin
          state_nxt = LGP_IDLE;
          timer_nxt = '0;
        end
        else
        begin
          timer_nxt = timer_r - 8'h01;
        end
      end
      default:
      begin
        state_nxt = LGP_IDLE;
        timer_nxt = '0;
      end
    endcase
  end

  // Disable wins over any tick, so the counter restarts from zero on release
  assign gs_count_nxt = blank_r ? GS_RST : (gs_tick ? gs_count_r + 16'h0001 : gs_count_r);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sck_meta_r <= 1'b0;
      sck_sync_r <= 1'b0;
      sck_prev_r <= 1'b0;
      sdi_meta_r <= 1'b0;
      sdi_sync_r <= 1'b0;
    end
    else if (ce_i)
    begin
      sck_meta_r <= shift_clock_in_i;
      sck_sync_r <= sck_meta_r;
      sck_prev_r <= sck_sync_r;
      sdi_meta_r <= serial_data_in_i;
      sdi_sync_r <= sdi_meta_r;
    end
  end

  // Contents are undefined to the host; zero is just a tidy choice
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_r <= SHIFT_RST;
      state_r <= LGP_IDLE;
      timer_r <= '0;
    end
    else if (ce_i)
    begin
      shift_r <= shift_nxt;
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blank_r    <= BLANK_RST;
      edge_sel_r <= 1'b0;
      clk_src_r  <= 1'b0;
      bc_red_r   <= BC_RST;
      bc_green_r <= BC_RST;
      bc_blue_r  <= BC_RST;
    end
    else if (ce_i && latch_strobe)
    begin
      blank_r    <= shift_r[BLANK_BIT];
      edge_sel_r <= shift_r[EDGE_SEL_BIT];
      clk_src_r  <= shift_r[CLK_SRC_BIT];
      bc_red_r   <= shift_r[BC_RED_LSB +: BC_W];
      bc_green_r <= shift_r[BC_GREEN_LSB +: BC_W];
      bc_blue_r  <= shift_r[BC_BLUE_LSB +: BC_W];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      int_div_r  <= '0;
      int_clk_r  <= 1'b0;
      gs_count_r <= GS_RST;
    end
    else if (ce_i)
    begin
      int_div_r  <= int_wrap ? '0 : int_div_r + 4'h1;
      int_clk_r  <= int_clk_r ^ int_wrap;
      gs_count_r <= gs_count_nxt;
    end
  end

  lgp_gs_if gs_if ();

  assign gs_if.load    = latch_strobe;
  assign gs_if.load_gs = shift_r[GS_LSB +: GS_W*NUM_CH];
  assign gs_if.blank   = blank_r;
  assign gs_if.count   = gs_count_r;

  lgp_gs_bank u_bank (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .gs_if   (gs_if)
  );

  // Brightness codes drive the group current DACs straight from the latch
  assign serial_data_out_o              = shift_r[SHIFT_W-1];
  assign sink_output_o                  = gs_if.on;
  assign group_brightness_value_red_o   = bc_red_r;
  assign group_brightness_value_green_o = bc_green_r;
  assign group_brightness_value_blue_o  = bc_blue_r;

  // Helper: cycles since last synchronised shift edge
  logic [TIMER_W-1:0] idle_cyc_r;
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_cyc_r <= '0;
    end
    else if (ce_i)
    begin
      idle_cyc_r <= sck_rise ? '0 : (&idle_cyc_r ? idle_cyc_r : idle_cyc_r + 8'h01);
    end
  end

  AST_POWERUP_BLANK: assert property (@(posedge clock_i) disable iff (rst_i)
    $past(rst_i) |-> blank_r)
    else $error("disable not set after reset");

  AST_BLANK_HOLDS_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && blank_r) |=> (gs_count_r == 16'h0000))
    else $error("counter not held at zero");

  AST_COUNT_STEP: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !blank_r && gs_tick) |=> (gs_count_r == $past(gs_count_r) + 16'h0001))
    else $error("counter missed a reference edge");

  AST_COUNT_STILL: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !blank_r && !gs_tick) |=> $stable(gs_count_r))
    else $error("counter moved without an edge");

  AST_EXT_SOURCE: assert property (@(posedge clock_i) disable iff (rst_i)
    (clk_src_r && !sck_rise && !sck_fall) |-> !gs_tick)
    else $error("external source ticked without shift edge");

  AST_SHIFT_IN: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && sck_rise) |=> (shift_r[0] == $past(sdi_sync_r))
      && (shift_r[SHIFT_W-1:1] == $past(shift_r[SHIFT_W-2:0])))
    else $error("shift register did not shift");

  AST_LATCH_DELAY: assert property (@(posedge clock_i) disable iff (rst_i)
    latch_strobe |-> (idle_cyc_r == LATCH_DELAY_LD - 8'h01))
    else $error("latch strobe at wrong delay");

  AST_LATCH_TOGETHER: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && latch_strobe) |=> (blank_r == $past(shift_r[BLANK_BIT]))
      && (edge_sel_r == $past(shift_r[EDGE_SEL_BIT]))
      && (clk_src_r == $past(shift_r[CLK_SRC_BIT])))
    else $error("control fields not latched together");

  AST_BC_AT_ONCE: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && latch_strobe) |=>
      (group_brightness_value_red_o == $past(shift_r[BC_RED_LSB +: BC_W]))
      && (group_brightness_value_blue_o == $past(shift_r[BC_BLUE_LSB +: BC_W])))
    else $error("brightness not applied at once");

  AST_BC_STABLE: assert property (@(posedge clock_i) disable iff (rst_i)
    !latch_strobe |=> $stable(group_brightness_value_green_o))
    else $error("brightness changed without strobe");

  AST_BC_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
    !latch_strobe |=> $stable(group_brightness_value_red_o)
      && $stable(group_brightness_value_blue_o))
    else $error("brightness moved without strobe");

  AST_SDO_SHIFTS: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && sck_rise) |=> (serial_data_out_o == $past(shift_r[SHIFT_W-2])))
    else $error("serial output did not follow shift");

  AST_EDGE_REARMS: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && sck_rise) |=> (state_r == LGP_ARMED) && (timer_r == LATCH_DELAY_LD))
    else $error("shift edge did not restart latch wait");

  AST_STROBE_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && latch_strobe) |=> (state_r == LGP_IDLE))
    else $error("sequencer stayed armed after strobe");

  AST_SINK_BLANK: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && blank_r) |=> (sink_output_o == '0))
    else $error("sink on while disabled");

  // Oscillator is a fixed divide, so its period tracks the system clock
  AST_INT_HALF: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && !int_wrap) |=> $stable(int_clk_r))
    else $error("internal reference toggled early");

  AST_INT_TOGGLE: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && int_wrap) |=> (int_clk_r != $past(int_clk_r)))
    else $error("internal reference missed a toggle");

endmodule

// *** tb/lgp_host.sv ***
`timescale 1ns/10ps
module lgp_host (
  output logic shift_clock_in_o,
  output logic serial_data_in_o
);
  import lgp_pkg::*;

  initial
  begin
    shift_clock_in_o = 1'b0;
    serial_data_in_o = 1'b0;
  end

  // Sends w[n-1:0], msb first; clock idles low between frames
  task automatic send(input logic [SHIFT_W-1:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data_in_o = w[i];
      #40 shift_clock_in_o = 1'b1;
      #40 shift_clock_in_o = 1'b0;
    end
    // No pull on the line, so the released data shows a changed level
    serial_data_in_o = ~serial_data_in_o;
  endtask

  // Lone clock level for counter edge tests; data left as it is
  task automatic set_clock(input logic lvl);
    shift_clock_in_o = lvl;
  endtask
endmodule

// *** tb/test_led_grayscale_pwm_brightness.sv ***
`timescale 1ns/10ps
module test_led_grayscale_pwm_brightness;
  import lgp_pkg::*;
  logic               clock_i;
  logic               rst_i;
  logic               ce_i;
  logic               sck;
  logic               sdi;
  logic               sdo;
  logic [NUM_CH-1:0]  sink;
  lgp_bc_t            bc_r;
  lgp_bc_t            bc_g;
  lgp_bc_t            bc_b;
  int                 error_cnt;
  int                 comparisons;
  int                 on_cnt [NUM_CH];
  logic [SHIFT_W-1:0] w;
  logic [SHIFT_W-1:0] w2;

  lgp_host host (.shift_clock_in_o(sck), .serial_data_in_o(sdi));

  lgp_top dut (
    .clock_i                        (clock_i),
    .rst_i                          (rst_i),
    .ce_i                           (ce_i),
    .shift_clock_in_i               (sck),
    .serial_data_in_i               (sdi),
    .serial_data_out_o              (sdo),
    .sink_output_o                  (sink),
    .group_brightness_value_red_o   (bc_r),
    .group_brightness_value_green_o (bc_g),
    .group_brightness_value_blue_o  (bc_b)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task results();
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // On-time counts allow for the unknown phase of the first count step
  task chk_on(input int ch, input int exp, input int tol);
    comparisons++;
    if (on_cnt[ch] < exp - tol || on_cnt[ch] > exp + tol)
    begin
      error_cnt++;
      $display("FAIL on_time ch%0d expected %0d seen %0d", ch, exp, on_cnt[ch]);
    end
  endtask

  task measure(input int cycles);
    on_cnt = '{default: 0};
    repeat (cycles)
    begin
      @(negedge clock_i);
      for (int n = 0; n < NUM_CH; n++)
        on_cnt[n] += (sink[n] === 1'b0) ? 0 : ((sink[n] === 1'b1) ? 1 : 100000);
    end
  endtask

  task wait_latch();
    repeat (LATCH_DELAY_CYC + 20) @(negedge clock_i);
  endtask

  task t_reset();
    measure(200);
    for (int n = 0; n < NUM_CH; n++)
      chk_on(n, 0, 0);
    chk("sink", '0, {4'h0, sink});
    chk("sdo_reset", 16'h0000, {15'h0, sdo});
  endtask

  task t_write(input lgp_bc_t red_early);
    host.send(w, SHIFT_W);
    repeat (150) @(negedge clock_i);
    chk("bc_red_early", {9'h0, red_early}, {9'h0, bc_r});
    measure(4100);
    chk("bc_red", 16'h007f, {9'h0, bc_r});
    chk("bc_green", 16'h0000, {9'h0, bc_g});
    chk("bc_blue", 16'h0055, {9'h0, bc_b});
    chk("sdo", {15'h0, w[SHIFT_W-1]}, {15'h0, sdo});
    chk_on(0, 0, 0);
    chk_on(1, 160, 20);
    chk_on(2, 180, 20);
    chk_on(3, 40, 20);
    chk_on(4, 4100 - (LATCH_DELAY_CYC + 5 - 150), 25);
  endtask

  task t_blank();
    w2 = w;
    w2[BLANK_BIT] = 1'b1;
    w2[BC_RED_LSB +: BC_W] = 7'h11;
    host.send(w2, SHIFT_W);
    wait_latch();
    chk("bc_red_blank", 16'h0011, {9'h0, bc_r});
    measure(2000);
    for (int n = 0; n < NUM_CH; n++)
      chk_on(n, 0, 0);
    t_write(7'h11);
  endtask

  task t_partial();
    w2 = {w[SHIFT_W-9:0], 8'ha5};
    host.send({216'h0, 8'ha5}, 8);
    wait_latch();
    chk("part_red", {9'h0, w2[BC_RED_LSB +: BC_W]}, {9'h0, bc_r});
    chk("part_green", {9'h0, w2[BC_GREEN_LSB +: BC_W]}, {9'h0, bc_g});
    chk("part_blue", {9'h0, w2[BC_BLUE_LSB +: BC_W]}, {9'h0, bc_b});
    chk("part_sdo", {15'h0, w2[SHIFT_W-1]}, {15'h0, sdo});
  endtask

  // Shift clock idle after the frame, so an external-clocked counter stays at zero
  task t_extsrc();
    for (int e = 0; e < 2; e++)
    begin
      w2 = w;
      w2[BLANK_BIT] = 1'b1;
      host.send(w2, SHIFT_W);
      wait_latch();
      w2[BLANK_BIT] = 1'b0;
      w2[CLK_SRC_BIT] = 1'b1;
      w2[EDGE_SEL_BIT] = e[0];
      w2[3*GS_W +: GS_W] = 16'h0001;
      host.send(w2, SHIFT_W);
      wait_latch();
      measure(2000);
      chk_on(3, 2000, 0);
      chk_on(1, 2000, 0);
      chk_on(0, 0, 0);
      host.set_clock(1'b1);
      repeat (20) @(negedge clock_i);
      chk("ext_rise", {15'h0, ~e[0]}, {15'h0, sink[3]});
      host.set_clock(1'b0);
      repeat (20) @(negedge clock_i);
      chk("ext_fall", 16'h0000, {15'h0, sink[3]});
      wait_latch();
    end
  endtask

  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    w = '0;
    w[BC_RED_LSB +: BC_W] = 7'h7f;
    w[BC_BLUE_LSB +: BC_W] = 7'h55;
    w[1*GS_W +: GS_W] = 16'h0400;
    w[2*GS_W +: GS_W] = 16'h0401;
    w[3*GS_W +: GS_W] = 16'h0081;
    w[4*GS_W +: GS_W] = 16'hffff;
    w[SHIFT_W-1] = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_write(7'h00);
    t_blank();
    t_partial();
    t_extsrc();
    results();
  end

  initial
  begin
    #400000;
    error_cnt++;
    results();
  end
endmodule
